/* File: dtv_cfg.svh */
// Named constants for the duty-to-target voltage controller
`ifndef DTV_CFG_SVH
`define DTV_CFG_SVH

// ----------------------------------------------------------------------------
// Register map and field layout
// ----------------------------------------------------------------------------
`define DTV_REG_ADDR_TARGET_CTRL 8'hae
`define DTV_CTRL_WMASK           16'h07ff
`define DTV_RST_TARGET_CTRL      16'h0000
`define DTV_LPF_MSB              10
`define DTV_LPF_LSB              9
`define DTV_FLAG_DLY_MSB         8
`define DTV_FLAG_DLY_LSB         6
`define DTV_GAIN_MODE_BIT        5
`define DTV_AVG_MSB              4
`define DTV_AVG_LSB              3
`define DTV_HYS_MSB              2
`define DTV_HYS_LSB              0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DTV_CLK_PERIOD_NS        50
`define DTV_FLAG_STEP_US         20
`define DTV_FLAG_STEP_CYC        ((`DTV_FLAG_STEP_US * 1000 + `DTV_CLK_PERIOD_NS - 1) / `DTV_CLK_PERIOD_NS)
`define DTV_LPF_BASE_MS          6
`define DTV_LPF_REF_KHZ          500
`define DTV_LPF_BASE_SHIFT       3
`define DTV_LPF_PRESCALE         ((`DTV_LPF_BASE_MS * `DTV_LPF_REF_KHZ) >> `DTV_LPF_BASE_SHIFT)

// ----------------------------------------------------------------------------
// Arithmetic
// ----------------------------------------------------------------------------
`define DTV_AVG_BASE_LOG2        2
`define DTV_GAIN_FRAC            12
`define DTV_GAIN_DEV_PCT         10
`define DTV_PCT_FULL             100

`endif

/* File: dtv_cmd_src.sv */
// Processor-side model driving the duty-encoded command pin
`timescale 1ns/100ps
module dtv_cmd_src (
  input  wire logic        i_clk,
  input  wire logic        i_en,
  input  wire logic [15:0] i_high_cyc,
  input  wire logic [15:0] i_low_cyc,
  output logic             o_pin
);
  initial o_pin = 1'b0;
  // Whole pulses only: a change of length lands on the next pulse
  always
  begin
    @(posedge i_clk);
    #1;
    if (i_en)
    begin
      o_pin = 1'b1;
      repeat (i_high_cyc) @(posedge i_clk);
      #1;
      o_pin = 1'b0;
      repeat (i_low_cyc - 16'h0001) @(posedge i_clk);
    end
  end
endmodule

/* File: dtv_ctrl.sv */
// Duty-cycle command to target output voltage controller
//
// Behaviour
// [R1] Control bits 15:11 ignore writes, read zero
// [R2] Two-bit code picks period/on-time filter constant
// [R3] Transition flag held for 20 us steps
// [R4] Bus voltage control clears flag without delay
// [R5] Target equals on-time times gain plus minimum
// [R6] Gain mode zero uses stored gain
// [R7] Adaptive gain updates beyond hysteresis, within ten percent
// [R8] Two-bit code picks 4 to 32 averaged samples
// [R9] Three-bit hysteresis threshold for adaptive gain update
// [R10] Target recomputed per averaged result, else held
`timescale 1ns/100ps
`include "dtv_cfg.svh"
module dtv_ctrl (
  input  wire logic                I_MCLK,
  input  wire logic                I_RST_N,
  input  wire logic                I_PWM_CMD,
  input  wire logic                I_REG_WR,
  input  wire dtv_pkg::dtv_addr_type I_REG_ADDR,
  input  wire dtv_pkg::dtv_word_type I_REG_WDATA,
  output dtv_pkg::dtv_word_type    O_REG_RDATA,
  input  wire dtv_pkg::dtv_word_type I_STORED_GAIN,
  input  wire dtv_pkg::dtv_word_type I_CALC_GAIN,
  input  wire logic                I_CALC_GAIN_VALID,
  input  wire dtv_pkg::dtv_word_type I_MINIMUM_OUTPUT_VALUE,
  input  wire logic                I_BUS_VOLTAGE_CONTROL_SELECT,
  input  wire logic                I_TRANSITION_START,
  input  wire logic                I_TRANSITION_DONE,
  output logic                     O_VOLTAGE_TRANSITION,
  output dtv_pkg::dtv_word_type    O_MEASURED_ON_TIME,
  output dtv_pkg::dtv_word_type    O_TARGET_VOLTAGE,
  output logic                     O_TARGET_VALID,
  output dtv_pkg::dtv_word_type    O_CURRENT_GAIN,
  output dtv_pkg::dtv_word_type    O_FILTERED_PERIOD,
  output dtv_pkg::dtv_word_type    O_FILTERED_ON_TIME
);
  import dtv_pkg::*;

  localparam int PRE_W = $clog2(`DTV_LPF_PRESCALE);
  localparam int STEP  = `DTV_FLAG_STEP_CYC;

  if (STEP < 1 || STEP > 1023 || `DTV_LPF_PRESCALE < 2)
  begin : g_chk
    $error("dtv_ctrl: timing constants out of range");
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  dtv_word_type ctrl_q;
  dtv_word_type rdata_q;
  logic         addr_hit;

  assign addr_hit = (I_REG_ADDR == `DTV_REG_ADDR_TARGET_CTRL);

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      ctrl_q <= `DTV_RST_TARGET_CTRL;
    else if (I_REG_WR && addr_hit)
      ctrl_q <= I_REG_WDATA & `DTV_CTRL_WMASK; // [R1]
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      rdata_q <= '0;
    else
      rdata_q <= addr_hit ? (ctrl_q & `DTV_CTRL_WMASK) : '0; // [R1]
  end

  assign O_REG_RDATA = rdata_q;

  logic [1:0] lpf_sel;
  logic [2:0] flag_dly;
  logic       gain_adapt_mode;
  logic [1:0] target_average_select;
  logic [2:0] gain_hysteresis;

  assign lpf_sel               = ctrl_q[`DTV_LPF_MSB:`DTV_LPF_LSB];
  assign flag_dly              = ctrl_q[`DTV_FLAG_DLY_MSB:`DTV_FLAG_DLY_LSB];
  assign gain_adapt_mode       = ctrl_q[`DTV_GAIN_MODE_BIT];
  assign target_average_select = ctrl_q[`DTV_AVG_MSB:`DTV_AVG_LSB];
  assign gain_hysteresis       = ctrl_q[`DTV_HYS_MSB:`DTV_HYS_LSB];

  // --------------------------------------------------------------------------
  // Command pin capture and on-time / period measurement
  // --------------------------------------------------------------------------
  logic         pwm_s1_q;
  logic         pwm_s2_q;
  logic         pwm_s3_q;
  logic         pwm_rise;
  logic         pwm_fall;
  dtv_word_type hi_cnt_q;
  dtv_word_type per_cnt_q;
  dtv_word_type on_time_q;
  dtv_word_type period_q;
  logic         on_valid_q;
  logic         per_valid_q;

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      pwm_s1_q <= 1'b0;
      pwm_s2_q <= 1'b0;
      pwm_s3_q <= 1'b0;
    end
    else
    begin
      pwm_s1_q <= I_PWM_CMD;
      pwm_s2_q <= pwm_s1_q;
      pwm_s3_q <= pwm_s2_q;
    end
  end

  assign pwm_rise = pwm_s2_q & ~pwm_s3_q;
  assign pwm_fall = ~pwm_s2_q & pwm_s3_q;

  // Counters saturate so a stuck pin reads as full scale, not a wrapped value
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      hi_cnt_q    <= '0;
      per_cnt_q   <= '0;
      on_time_q   <= '0;
      period_q    <= '0;
      on_valid_q  <= 1'b0;
      per_valid_q <= 1'b0;
    end
    else
    begin
      on_valid_q  <= pwm_fall;
      per_valid_q <= pwm_rise;
      if (pwm_rise)
      begin
        period_q  <= per_cnt_q;
        per_cnt_q <= 16'h0001;
        hi_cnt_q  <= 16'h0001;
      end
      else
      begin
        if (per_cnt_q != 16'hffff)
          per_cnt_q <= per_cnt_q + 16'h0001;
        if (pwm_s2_q && hi_cnt_q != 16'hffff)
          hi_cnt_q <= hi_cnt_q + 16'h0001;
      end
      if (pwm_fall)
        on_time_q <= hi_cnt_q;
    end
  end

  assign O_MEASURED_ON_TIME = on_time_q;

  // --------------------------------------------------------------------------
  // Efficiency low-pass filters, fed once per prescaled group of periods
  // --------------------------------------------------------------------------
  // Sampling one period in every group fixes the constant in periods, so it
  // is exact only at a 500 kHz switching rate, and the periods in between are ignored.
  logic [PRE_W-1:0] pre_cnt_q;
  logic             lpf_valid_q;
  dtv_lpf_if #(.W(16)) per_if ();
  dtv_lpf_if #(.W(16)) ton_if ();

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      pre_cnt_q   <= '0;
      lpf_valid_q <= 1'b0;
    end
    else
    begin
      lpf_valid_q <= 1'b0;
      if (per_valid_q)
      begin
        if (pre_cnt_q == PRE_W'(`DTV_LPF_PRESCALE - 1))
        begin
          pre_cnt_q   <= '0;
          lpf_valid_q <= 1'b1; // [R2]
        end
        else
          pre_cnt_q <= pre_cnt_q + PRE_W'(1);
      end
    end
  end

  assign per_if.valid  = lpf_valid_q;
  assign per_if.sample = period_q;
  assign per_if.sel    = lpf_sel;
  assign ton_if.valid  = lpf_valid_q;
  assign ton_if.sample = on_time_q;
  assign ton_if.sel    = lpf_sel;

  dtv_lpf #(.W(16)) u_per_lpf (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .lpf     (per_if.filt)
  );

  dtv_lpf #(.W(16)) u_ton_lpf (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .lpf     (ton_if.filt)
  );

  assign O_FILTERED_PERIOD  = per_if.filtered;
  assign O_FILTERED_ON_TIME = ton_if.filtered;

  // --------------------------------------------------------------------------
  // Block average of on-time for the target path
  // --------------------------------------------------------------------------
  logic [20:0]  avg_acc_q;
  logic [4:0]   avg_cnt_q;
  dtv_word_type avg_on_q;
  logic         avg_valid_q;
  logic [2:0]   avg_log2;
  logic [20:0]  avg_sum;
  logic [4:0]   avg_last;

  assign avg_log2 = 3'(`DTV_AVG_BASE_LOG2) + {1'b0, target_average_select}; // [R8]
  assign avg_last = 5'((6'h01 << avg_log2) - 6'h01);
  assign avg_sum  = avg_acc_q + {5'h00, on_time_q};

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      avg_acc_q   <= '0;
      avg_cnt_q   <= '0;
      avg_on_q    <= '0;
      avg_valid_q <= 1'b0;
    end
    else
    begin
      avg_valid_q <= 1'b0;
      if (on_valid_q)
      begin
        if (avg_cnt_q >= avg_last)
        begin
          avg_on_q    <= 16'(avg_sum >> avg_log2); // [R8]
          avg_valid_q <= 1'b1;
          avg_acc_q   <= '0;
          avg_cnt_q   <= '0;
        end
        else
        begin
          avg_acc_q <= avg_sum;
          avg_cnt_q <= avg_cnt_q + 5'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Current gain
  // --------------------------------------------------------------------------
  dtv_word_type gain_q;
  dtv_word_type gain_diff;
  logic [22:0]  dev_lhs;
  logic [22:0]  dev_rhs;
  logic         gain_take;

  assign gain_diff = (I_CALC_GAIN > gain_q) ? (I_CALC_GAIN - gain_q) : (gain_q - I_CALC_GAIN);
  assign dev_lhs   = 23'(gain_diff) * 23'(`DTV_PCT_FULL);
  assign dev_rhs   = 23'(gain_q) * 23'(`DTV_GAIN_DEV_PCT);
  assign gain_take = I_CALC_GAIN_VALID
                   && (gain_diff > {13'h0000, gain_hysteresis}) // [R9]
                   && (dev_lhs <= dev_rhs); // [R7]

  // Tracking the stored gain while in mode zero makes it the start value of mode one
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      gain_q <= '0;
    else if (!gain_adapt_mode)
      gain_q <= I_STORED_GAIN; // [R6]
    else if (gain_take)
      gain_q <= I_CALC_GAIN; // [R7]
  end

  assign O_CURRENT_GAIN = gain_q;

  // --------------------------------------------------------------------------
  // Target voltage
  // --------------------------------------------------------------------------
  dtv_word_type target_q;
  logic         target_valid_q;
  logic [31:0]  prod;
  logic [20:0]  target_sum;

  assign prod       = avg_on_q * gain_q;
  assign target_sum = 21'(prod >> `DTV_GAIN_FRAC) + {5'h00, I_MINIMUM_OUTPUT_VALUE}; // [R5]

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      target_q       <= '0;
      target_valid_q <= 1'b0;
    end
    else
    begin
      target_valid_q <= avg_valid_q;
      if (avg_valid_q) // [R10]
        target_q <= (target_sum[20:16] != 5'h00) ? 16'hffff : target_sum[15:0]; // [R5]
    end
  end

  assign O_TARGET_VOLTAGE = target_q;
  assign O_TARGET_VALID   = target_valid_q;

  // --------------------------------------------------------------------------
  // Transition flag
  // --------------------------------------------------------------------------
  dtv_flag_state_type flag_st_q;
  logic [11:0]        dly_cnt_q;
  logic               flag_q;

  // A new start always wins over a clear in the same cycle
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      flag_st_q <= DTV_FLAG_IDLE;
      dly_cnt_q <= '0;
      flag_q    <= 1'b0;
    end
    else
    begin
      case (flag_st_q)
        DTV_FLAG_IDLE:
        begin
          if (I_TRANSITION_START)
          begin
            flag_st_q <= DTV_FLAG_ACTIVE;
            flag_q    <= 1'b1;
          end
        end
        DTV_FLAG_ACTIVE:
        begin
          if (!I_TRANSITION_START && I_TRANSITION_DONE)
          begin
            if (I_BUS_VOLTAGE_CONTROL_SELECT || flag_dly == 3'h0)
            begin
              flag_st_q <= DTV_FLAG_IDLE; // [R4]
              flag_q    <= 1'b0;
            end
            else
            begin
              flag_st_q <= DTV_FLAG_HOLD;
              dly_cnt_q <= 12'(flag_dly * STEP - 1); // [R3]
            end
          end
        end
        DTV_FLAG_HOLD:
        begin
          if (I_TRANSITION_START)
            flag_st_q <= DTV_FLAG_ACTIVE;
          else if (I_BUS_VOLTAGE_CONTROL_SELECT || dly_cnt_q == 12'h000)
          begin
            flag_st_q <= DTV_FLAG_IDLE; // [R3] [R4]
            flag_q    <= 1'b0;
          end
          else
            dly_cnt_q <= dly_cnt_q - 12'h001;
        end
        default:
        begin
          flag_st_q <= DTV_FLAG_IDLE;
          flag_q    <= 1'b0;
        end
      endcase
    end
  end

  assign O_VOLTAGE_TRANSITION = flag_q;
endmodule

/* File: dtv_ctrl_asserts.sv */
// Port-level checker for the duty-to-target voltage controller
`timescale 1ns/100ps
module dtv_ctrl_asserts (
  input wire logic                  I_MCLK,
  input wire logic                  I_RST_N,
  input wire logic                  I_REG_WR,
  input wire dtv_pkg::dtv_addr_type I_REG_ADDR,
  input wire dtv_pkg::dtv_word_type I_REG_WDATA,
  input wire dtv_pkg::dtv_word_type O_REG_RDATA,
  input wire dtv_pkg::dtv_word_type I_STORED_GAIN,
  input wire dtv_pkg::dtv_word_type I_CALC_GAIN,
  input wire logic                  I_CALC_GAIN_VALID,
  input wire logic                  I_BUS_VOLTAGE_CONTROL_SELECT,
  input wire logic                  I_TRANSITION_START,
  input wire logic                  I_TRANSITION_DONE,
  input wire logic                  O_VOLTAGE_TRANSITION,
  input wire dtv_pkg::dtv_word_type O_TARGET_VOLTAGE,
  input wire logic                  O_TARGET_VALID,
  input wire dtv_pkg::dtv_word_type O_CURRENT_GAIN
);
  import dtv_pkg::*;
  dtv_word_type ctrl_q;
  dtv_word_type hold_q;
  logic [16:0]  gdiff;
  logic         take_ok;
  // ----------------------------------------------------------------
  // Shadow of the control word and flag hold counter
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK)
    if (!I_RST_N) ctrl_q <= 16'h0000;
    else if (I_REG_WR && I_REG_ADDR == 8'hae) ctrl_q <= I_REG_WDATA & 16'h07ff;
  // Counts edges since a completion while the flag stays up
  always_ff @(posedge I_MCLK)
    if (!I_RST_N) hold_q <= 16'h0000;
    else if (I_TRANSITION_DONE && O_VOLTAGE_TRANSITION && !I_TRANSITION_START) hold_q <= 16'h0001;
    else if (hold_q != 16'h0000 && O_VOLTAGE_TRANSITION) hold_q <= hold_q + 16'h0001;
    else hold_q <= 16'h0000;
  always_comb
  begin
    gdiff   = (I_CALC_GAIN > O_CURRENT_GAIN) ? 17'(I_CALC_GAIN - O_CURRENT_GAIN) : 17'(O_CURRENT_GAIN - I_CALC_GAIN);
    take_ok = gdiff > 17'(ctrl_q[2:0]) && 24'(gdiff) * 24'd100 <= 24'(O_CURRENT_GAIN) * 24'd10;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  property p_rsv_zero; O_REG_RDATA[15:11] == 5'h00; endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");
  property p_wr_read; (I_REG_WR && I_REG_ADDR == 8'hae) ##1 (!I_REG_WR && I_REG_ADDR == 8'hae)[*2]
    |=> O_REG_RDATA == ($past(I_REG_WDATA, 3) & 16'h07ff); endproperty
  a_wr_read: assert property (p_wr_read) else $error("control readback wrong");
  property p_unmapped; (I_REG_ADDR != 8'hae)[*2] |=> O_REG_RDATA == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_flag_set; I_TRANSITION_START && !O_VOLTAGE_TRANSITION |-> ##[1:2] O_VOLTAGE_TRANSITION; endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not raised");
  property p_flag_hold; hold_q != 16'h0000 && 32'(hold_q) < 32'(ctrl_q[8:6]) * 400
    && !I_BUS_VOLTAGE_CONTROL_SELECT |-> O_VOLTAGE_TRANSITION; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared early");
  property p_flag_clear; 32'(hold_q) <= 32'(ctrl_q[8:6]) * 400 + 3; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag held too long");
  property p_sel_clear; I_TRANSITION_DONE && I_BUS_VOLTAGE_CONTROL_SELECT && O_VOLTAGE_TRANSITION
    && !I_TRANSITION_START |-> ##[1:2] !O_VOLTAGE_TRANSITION; endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("bus control flag not cleared");
  property p_gain_fixed; $past(I_RST_N) && !ctrl_q[5] && !$past(ctrl_q[5])
    |-> O_CURRENT_GAIN == $past(I_STORED_GAIN); endproperty
  a_gain_fixed: assert property (p_gain_fixed) else $error("gain not the stored one");
  property p_gain_take; ctrl_q[5] && I_CALC_GAIN_VALID && take_ok |=> O_CURRENT_GAIN == $past(I_CALC_GAIN); endproperty
  a_gain_take: assert property (p_gain_take) else $error("gain update missed");
  property p_gain_keep; ctrl_q[5] && !(I_CALC_GAIN_VALID && take_ok) |=> $stable(O_CURRENT_GAIN); endproperty
  a_gain_keep: assert property (p_gain_keep) else $error("gain changed wrongly");
  property p_target_hold; $past(I_RST_N) && !O_TARGET_VALID |-> $stable(O_TARGET_VOLTAGE); endproperty
  a_target_hold: assert property (p_target_hold) else $error("target moved between updates");
endmodule

bind dtv_ctrl dtv_ctrl_asserts u_chk (.I_MCLK, .I_RST_N, .I_REG_WR, .I_REG_ADDR, .I_REG_WDATA, .O_REG_RDATA,
  .I_STORED_GAIN, .I_CALC_GAIN, .I_CALC_GAIN_VALID, .I_BUS_VOLTAGE_CONTROL_SELECT, .I_TRANSITION_START,
  .I_TRANSITION_DONE, .O_VOLTAGE_TRANSITION, .O_TARGET_VOLTAGE, .O_TARGET_VALID, .O_CURRENT_GAIN);

/* File: dtv_lpf.sv */
// First-order low-pass filter with a selectable time constant
`timescale 1ns/100ps
`include "dtv_cfg.svh"
module dtv_lpf #(
  parameter int W = 16
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  dtv_lpf_if.filt   lpf
);
  localparam int AW = W + 7;

  if (W < 4)
  begin : g_chk
    $error("dtv_lpf: W too small");
  end

  logic [AW-1:0] acc_q;
  logic [AW-1:0] acc_d;
  logic [W-1:0]  filt_q;
  logic [2:0]    shift;

  // Time constant doubles per select code
  assign shift = 3'(`DTV_LPF_BASE_SHIFT) + {1'b0, lpf.sel}; // [R2]
  assign acc_d = acc_q + AW'(lpf.sample) - (acc_q >> shift);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      acc_q <= '0;
    else if (lpf.valid)
      acc_q <= acc_d;
  end

  // A change of select leaves the state unscaled; the output steps once and recovers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      filt_q <= '0;
    else
      filt_q <= W'(acc_q >> shift);
  end

  assign lpf.filtered = filt_q;
endmodule

/* File: dtv_lpf_if.sv */
// Sample and result path between the controller and its low-pass filters
`timescale 1ns/100ps
interface dtv_lpf_if #(parameter int W = 16);
  logic         valid;
  logic [W-1:0] sample;
  logic [1:0]   sel;
  logic [W-1:0] filtered;
  modport src  (output valid, output sample, output sel, input filtered);
  modport filt (input valid, input sample, input sel, output filtered);
endinterface

/* File: dtv_pkg.sv */
// Types shared by the duty-to-target voltage controller
package dtv_pkg;
  typedef logic [15:0] dtv_word_type;
  typedef logic [7:0]  dtv_addr_type;
  typedef enum {DTV_FLAG_IDLE, DTV_FLAG_ACTIVE, DTV_FLAG_HOLD} dtv_flag_state_type;
endpackage

/* File: testbench.sv */
// Self-checking bench for the duty-to-target voltage controller
`timescale 1ns/100ps
module testbench;
  import dtv_pkg::*;
  logic         I_MCLK = 1'b0;
  logic         I_RST_N, I_PWM_CMD, I_REG_WR, I_CALC_GAIN_VALID, cmd_en;
  logic         I_BUS_VOLTAGE_CONTROL_SELECT, I_TRANSITION_START, I_TRANSITION_DONE;
  logic         O_VOLTAGE_TRANSITION, O_TARGET_VALID;
  dtv_addr_type I_REG_ADDR;
  dtv_word_type I_REG_WDATA, I_STORED_GAIN, I_CALC_GAIN, I_MINIMUM_OUTPUT_VALUE, hi_cyc, rd;
  dtv_word_type O_REG_RDATA, O_MEASURED_ON_TIME, O_TARGET_VOLTAGE, O_CURRENT_GAIN;
  dtv_word_type O_FILTERED_PERIOD, O_FILTERED_ON_TIME;
  int           num_errors, checks_done, cnt, s;

  always #25 I_MCLK = ~I_MCLK;

  dtv_cmd_src u_src (.i_clk(I_MCLK), .i_en(cmd_en), .i_high_cyc(hi_cyc), .i_low_cyc(16'd20), .o_pin(I_PWM_CMD));

  dtv_ctrl u_dut (.I_MCLK, .I_RST_N, .I_PWM_CMD, .I_REG_WR, .I_REG_ADDR, .I_REG_WDATA, .O_REG_RDATA,
    .I_STORED_GAIN, .I_CALC_GAIN, .I_CALC_GAIN_VALID, .I_MINIMUM_OUTPUT_VALUE, .I_BUS_VOLTAGE_CONTROL_SELECT,
    .I_TRANSITION_START, .I_TRANSITION_DONE, .O_VOLTAGE_TRANSITION, .O_MEASURED_ON_TIME, .O_TARGET_VOLTAGE,
    .O_TARGET_VALID, .O_CURRENT_GAIN, .O_FILTERED_PERIOD, .O_FILTERED_ON_TIME);

  // ----------------------------------------------------------------
  // Access and comparison tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input dtv_word_type got, input dtv_word_type exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask
  task automatic wr_reg(input dtv_addr_type a, input dtv_word_type d);
    I_REG_ADDR = a;
    I_REG_WDATA = d;
    I_REG_WR = 1'b1;
    tick(1);
    I_REG_WR = 1'b0;
  endtask
  // Read data lags the address, so the address is held three edges
  task automatic rd_reg(input dtv_addr_type a);
    I_REG_ADDR = a;
    tick(3);
    rd = O_REG_RDATA;
  endtask
  // Leaves in cnt the cycles since the previous call returned
  task automatic wait_valid;
    tick(1);
    for (cnt = 1; cnt < 4000 && O_TARGET_VALID !== 1'b1; cnt++) tick(1);
    if (O_TARGET_VALID !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t ns: no new target", $time);
      close_out;
    end
  endtask
  task automatic gain_try(input dtv_word_type calc, input dtv_word_type exp);
    I_CALC_GAIN = calc;
    I_CALC_GAIN_VALID = 1'b1;
    tick(1);
    I_CALC_GAIN_VALID = 1'b0;
    tick(2);
    check(O_CURRENT_GAIN, exp);
  endtask
  // Flag must stay up between lo and hi cycles after completion
  task automatic flag_run(input logic sel, input int lo, input int hi);
    I_BUS_VOLTAGE_CONTROL_SELECT = sel;
    I_TRANSITION_START = 1'b1;
    tick(1);
    I_TRANSITION_START = 1'b0;
    tick(2);
    check(16'(O_VOLTAGE_TRANSITION), 16'h0001);
    I_TRANSITION_DONE = 1'b1;
    tick(1);
    I_TRANSITION_DONE = 1'b0;
    for (cnt = 0; cnt < 4000 && O_VOLTAGE_TRANSITION === 1'b1; cnt++) tick(1);
    check(16'(cnt >= lo && cnt <= hi), 16'h0001);
    if (cnt >= 4000)
      close_out;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {I_RST_N, I_REG_WR, I_CALC_GAIN_VALID, cmd_en} = 4'h0;
    {I_BUS_VOLTAGE_CONTROL_SELECT, I_TRANSITION_START, I_TRANSITION_DONE} = 3'h0;
    {I_REG_ADDR, I_REG_WDATA, I_CALC_GAIN} = 40'h0;
    I_STORED_GAIN = 16'h2000;
    I_MINIMUM_OUTPUT_VALUE = 16'h0100;
    hi_cyc = 16'd20;
    tick(16);
    I_RST_N = 1'b1;
    rd_reg(8'hae);
    check(rd, 16'h0000);
    wr_reg(8'hae, 16'hffff);
    rd_reg(8'hae);
    check(rd, 16'h07ff);
    wr_reg(8'had, 16'h0000);
    rd_reg(8'had);
    check(rd, 16'h0000);
    rd_reg(8'hae);
    check(rd, 16'h07ff);
    $display("Test register access finished");
    cmd_en = 1'b1;
    for (s = 0; s < 4; s++)
    begin
      wr_reg(8'hae, (16'(s) << 9) | (16'(s) << 3));
      rd_reg(8'hae);
      check(rd, (16'(s) << 9) | (16'(s) << 3));
      wait_valid;
      wait_valid;
      wait_valid;
      check(16'(cnt), 16'd40 << (s + 2));
      check(O_TARGET_VOLTAGE, 16'h0128);
      check(O_CURRENT_GAIN, 16'h2000);
      check(O_MEASURED_ON_TIME, 16'd20);
    end
    hi_cyc = 16'd30;
    I_STORED_GAIN = 16'h1800;
    wait_valid;
    wait_valid;
    check(O_TARGET_VOLTAGE, 16'h012d);
    $display("Test target path finished");
    I_STORED_GAIN = 16'h2000;
    tick(2);
    wr_reg(8'hae, 16'h0023);
    I_STORED_GAIN = 16'h1000;
    tick(2);
    gain_try(16'h2002, 16'h2000);
    gain_try(16'h2100, 16'h2100);
    gain_try(16'h2600, 16'h2100);
    gain_try(16'h2104, 16'h2104);
    $display("Test adaptive gain finished");
    wr_reg(8'hae, 16'h0080);
    flag_run(1'b0, 799, 803);
    flag_run(1'b1, 0, 2);
    wr_reg(8'hae, 16'h0000);
    flag_run(1'b0, 0, 2);
    $display("Test transition flag finished");
    hi_cyc = 16'd20;
    I_RST_N = 1'b0;
    tick(4);
    I_RST_N = 1'b1;
    rd_reg(8'hae);
    check(rd, 16'h0000);
    for (cnt = 0; cnt < 20000 && O_FILTERED_PERIOD === 16'h0000; cnt++) tick(1);
    tick(2);
    check(O_FILTERED_PERIOD, 16'd5);
    check(O_FILTERED_ON_TIME, 16'd2);
    $display("Test period filter finished");
    close_out;
  end
endmodule
